// >>> logic/pcpsp_pkg.sv
/*
  Shared constants of the peak current phase-shifted bridge PWM block:
  register map, field positions, reset values and timing figures.
  Assumes a single 100 MHz time-base clock and an AXI4-Lite register bus.
*/
package pcpsp_pkg;

  // Time base
  localparam int          CLK_PERIOD_NS   = 10;       // 100 MHz system clock
  localparam int          SW_PERIOD_NS    = 10000;    // 100 kHz switching period
  // Up-down counting: one switching period is two ramps of PERIOD counts
  localparam int          PERIOD_CYCLES   = SW_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int          DB_DEFAULT_NS   = 100;      // Dead band after reset
  localparam int          DB_DEFAULT_CYC  = (DB_DEFAULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;    // Enable, ramp select, rectifier mode
  localparam logic [7:0]  ADDR_PERIOD     = 8'h04;    // Counter period shadow
  localparam logic [7:0]  ADDR_DEADBAND   = 8'h08;    // Leading and lagging dead bands
  localparam logic [7:0]  ADDR_RAMP_START = 8'h0C;    // Peak reference / ramp start shadow
  localparam logic [7:0]  ADDR_RAMP_SLOPE = 8'h10;    // Ramp decrement shadow
  localparam logic [7:0]  ADDR_STATUS     = 8'h14;    // Read-only live state

  // Control register fields
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_RAMP_BIT   = 1;
  localparam int          CTRL_MODE_LSB   = 2;        // Two-bit rectifier mode
  // Dead band register fields
  localparam int          DB_LEAD_LSB     = 0;        // Eight bits, leading leg
  localparam int          DB_LAG_LSB      = 8;        // Eight bits, lagging leg
  // Status register fields
  localparam int          STS_RAMP_LSB    = 0;        // Sixteen-bit ramp countdown value
  localparam int          STS_DIR_BIT     = 16;
  localparam int          STS_MODE_LSB    = 17;
  localparam int          STS_TRIP_BIT    = 19;

  // Reset values
  localparam logic [3:0]  CTRL_RST        = 4'h0;     // Mode, ramp select and enable
  localparam logic [15:0] PERIOD_RST      = 16'(PERIOD_CYCLES);
  localparam logic [7:0]  DB_RST          = 8'(DB_DEFAULT_CYC);
  localparam logic [15:0] RAMP_START_RST  = 16'h0000;
  localparam logic [15:0] RAMP_SLOPE_RST  = 16'h0000;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Rectifier modes
  typedef enum logic [1:0] {
    SR_OFF     = 2'h0,   // Diode current doubler
    SR_DIODE   = 2'h1,   // On during own diagonal overlap
    SR_FULL    = 2'h2,   // Off during opposite diagonal overlap
    SR_SPARE   = 2'h3    // Treated as off
  } pcpsp_srmode_t;

endpackage

// >>> logic/pcpsp_top.sv
/*
  Peak current mode phase-shifted full bridge PWM generator with
  rectifier drive, slope-compensation ramp and an AXI4-Lite register file.
  Assumes the analog comparator output arrives asynchronously and the ramp
  DAC and the gate drivers sit outside; one clock, asynchronous reset.
*/
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
// What this block does
// - Each leg switches at half duty, antiphase
// - Lagging leg phase offset sets power transfer
// - Comparator trip drives active lagging output low
// - Complementary lagging output rises after dead time
// - Falling ramp compensates the peak reference
// - Same peak reference for both halves
// - Leading outputs complementary, half duty, dead band
// - Lagging qualifier high on up-trip or period
// - Lagging qualifier low on down-trip or zero
// - Both trip events come from one compare event
// - Rising-edge delay on lagging output A
// - Output B is delayed, inverted qualifier
// - Trip forces falling edge of A or B
// - Trip latch clears at zero and period
// - Mode 0 holds rectifiers off
// - Mode 1 rectifier on during own overlap
// - Mode 2 rectifier off during opposite overlap
// - Mode changes cause no output glitch
// - Ramp starts at peak reference shadow
// - Selected ramp falls by decrement value
// - DAC takes ramp value upper twelve bits
// - Low four ramp bits act as prescaler
`timescale 1ns/1ps
module pcpsp_top
  import pcpsp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Comparator and DAC
  input  wire logic        peakTripIn,
  output logic [11:0]      rampDacOut,
  // Gate drives
  output logic             leadingLegOutA,
  output logic             leadingLegOutB,
  output logic             laggingLegOutA,
  output logic             laggingLegOutB,
  output logic             syncRectOut1,
  output logic             syncRectOut2
);

  // Register file
  logic          ctrlEn_r;            // Time base running
  logic          ctrlRampSel_r;       // DAC follows the falling ramp
  logic [1:0]    ctrlMode_r;          // Rectifier mode shadow
  logic [15:0]   periodShadow_r;      // Period, loaded at zero
  logic [7:0]    dbLead_r;            // Leading leg dead band
  logic [7:0]    dbLag_r;             // Lagging leg dead band
  logic [15:0]   rampStartShadow_r;   // Peak reference command
  logic [15:0]   rampSlopeShadow_r;   // Ramp decrement command

  // Bus slave state
  logic          awHeld_r;
  logic          wHeld_r;
  logic [7:0]    awAddr_r;
  logic [31:0]   wData_r;
  logic [3:0]    wStrb_r;
  logic          doWrite;

  // Time base state
  logic [15:0]   cnt_r;               // Up-down counter
  logic          dirUp_r;             // Counting up
  logic [15:0]   periodAct_r;         // Active period
  logic          zeroEvt;
  logic          prdEvt;

  // Trip path
  logic          tripSync1_r;         // First synchroniser stage
  logic          tripSync2_r;         // Second synchroniser stage
  logic          tripLatch_r;         // One trip per half cycle
  logic          tripEvt;
  logic          tripUp;
  logic          tripDown;

  // Qualifiers and dead band
  logic          leadAq_r;
  logic          lagAq_r;
  logic [1:0]    aqLeg;
  logic          aqPrev_r [2];        // Qualifier one clock ago, per leg
  logic [7:0]    dbCnt_r [2];
  logic [7:0]    dbVal   [2];
  logic [1:0]    outA_nxt;
  logic [1:0]    outB_nxt;

  // Ramp and rectifier
  logic [15:0]   ramp_r;              // Countdown value
  logic [15:0]   rampStartAct_r;
  logic [15:0]   rampSlopeAct_r;
  pcpsp_srmode_t srModeAct_r;

  // Merges written bytes into an old register value
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = newVal[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Write channel: address and data taken in either order, answer follows both
  assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awHeld_r      <= 1'b0;
      wHeld_r       <= 1'b0;
      awAddr_r      <= 8'h00;
      wData_r       <= 32'h00000000;
      wStrb_r       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        awHeld_r      <= 1'b1;
        awAddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        wHeld_r      <= 1'b1;
        wData_r      <= s_axi_wdata;
        wStrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        // Status and unmapped words refuse writes
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_r[7:2] <= ADDR_RAMP_SLOPE[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register updates with byte strobes; low two address bits ignored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {ctrlMode_r, ctrlRampSel_r, ctrlEn_r} <= CTRL_RST;
      periodShadow_r    <= PERIOD_RST;
      dbLead_r          <= DB_RST;
      dbLag_r           <= DB_RST;
      rampStartShadow_r <= RAMP_START_RST;
      rampSlopeShadow_r <= RAMP_SLOPE_RST;
    end else if (doWrite) begin
      unique case (awAddr_r[7:2])
        ADDR_CTRL[7:2]: begin
          ctrlEn_r      <= wStrb_r[0] ? wData_r[CTRL_EN_BIT] : ctrlEn_r;
          ctrlRampSel_r <= wStrb_r[0] ? wData_r[CTRL_RAMP_BIT] : ctrlRampSel_r;
          ctrlMode_r    <= wStrb_r[0] ? wData_r[CTRL_MODE_LSB +: 2] : ctrlMode_r;
        end
        ADDR_PERIOD[7:2]: begin
          periodShadow_r <= 16'(mergeBytes({16'h0, periodShadow_r}, wData_r, wStrb_r));
        end
        ADDR_DEADBAND[7:2]: begin
          {dbLag_r, dbLead_r} <= 16'(mergeBytes({16'h0, dbLag_r, dbLead_r}, wData_r,
                                                wStrb_r));
        end
        ADDR_RAMP_START[7:2]: begin
          // Controller writes the peak reference here once per period
          rampStartShadow_r <= 16'(mergeBytes({16'h0, rampStartShadow_r}, wData_r,
                                              wStrb_r));
        end
        ADDR_RAMP_SLOPE[7:2]: begin
          rampSlopeShadow_r <= 16'(mergeBytes({16'h0, rampSlopeShadow_r}, wData_r,
                                              wStrb_r));
        end
        default: begin
          // Refused; answered with an error response
        end
      endcase
    end
  end

  // Read channel: data registered on the same edge that takes the address
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      unique case (s_axi_araddr[7:2])
        ADDR_CTRL[7:2]:       s_axi_rdata <= {28'h0, ctrlMode_r, ctrlRampSel_r, ctrlEn_r};
        ADDR_PERIOD[7:2]:     s_axi_rdata <= {16'h0, periodShadow_r};
        ADDR_DEADBAND[7:2]:   s_axi_rdata <= {16'h0, dbLag_r, dbLead_r};
        ADDR_RAMP_START[7:2]: s_axi_rdata <= {16'h0, rampStartShadow_r};
        ADDR_RAMP_SLOPE[7:2]: s_axi_rdata <= {16'h0, rampSlopeShadow_r};
        ADDR_STATUS[7:2]: begin
          // Live state for software
          s_axi_rdata <= {12'h0, tripLatch_r, srModeAct_r, dirUp_r, ramp_r};
        end
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Boundary events of the up-down counter
  assign zeroEvt = ctrlEn_r && (cnt_r == 16'h0000);
  assign prdEvt  = ctrlEn_r && (cnt_r >= periodAct_r);

  // Up-down counter; period shadow moves to active at zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r       <= 16'h0000;
      dirUp_r     <= 1'b1;
      periodAct_r <= PERIOD_RST;
    end else if (!ctrlEn_r) begin
      cnt_r       <= 16'h0000;
      dirUp_r     <= 1'b1;
      periodAct_r <= periodShadow_r;
    end else if (zeroEvt) begin
      cnt_r       <= 16'h0001;
      dirUp_r     <= 1'b1;
      periodAct_r <= periodShadow_r;
    end else if (dirUp_r && !prdEvt) begin
      cnt_r <= cnt_r + 16'h0001;
    end else begin
      cnt_r   <= cnt_r - 16'h0001;
      dirUp_r <= 1'b0;
    end
  end

  // Comparator pin passes two flops before use
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tripSync1_r <= 1'b0;
      tripSync2_r <= 1'b0;
    end else begin
      tripSync1_r <= peakTripIn;
      tripSync2_r <= tripSync1_r;
    end
  end

  // One compare event feeds both directional trips
  assign tripEvt  = ctrlEn_r && tripSync2_r && !tripLatch_r;
  assign tripUp   = tripEvt && dirUp_r;
  assign tripDown = tripEvt && !dirUp_r;

  // Cycle-by-cycle latch; a trip in the clearing cycle still latches
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tripLatch_r <= 1'b0;
    end else if (tripEvt) begin
      tripLatch_r <= 1'b1;
    end else if (zeroEvt || prdEvt || !ctrlEn_r) begin
      tripLatch_r <= 1'b0;
    end
  end

  // Action qualifiers: leading fixed half duty, lagging moved by trips
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      leadAq_r <= 1'b0;
      lagAq_r  <= 1'b0;
    end else if (!ctrlEn_r) begin
      leadAq_r <= 1'b0;
      lagAq_r  <= 1'b0;
    end else begin
      if (zeroEvt) begin
        leadAq_r <= 1'b1;
      end else if (prdEvt) begin
        leadAq_r <= 1'b0;
      end
      // Trip position shifts the lagging edges against the leading ones
      if (tripUp || prdEvt) begin
        lagAq_r <= 1'b1;
      end else if (tripDown || zeroEvt) begin
        lagAq_r <= 1'b0;
      end
    end
  end

  assign aqLeg    = {lagAq_r, leadAq_r};
  assign dbVal[0] = dbLead_r;
  assign dbVal[1] = dbLag_r;

  // Dead band per leg: A gets a rising delay, B the inverted falling delay
  for (genvar i = 0; i < 2; i++) begin : g_leg
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        aqPrev_r[i] <= 1'b0;
        dbCnt_r[i]  <= 8'h00;
      end else begin
        aqPrev_r[i] <= aqLeg[i];
        if (aqLeg[i] != aqPrev_r[i]) begin
          dbCnt_r[i] <= 8'h01;
        end else if (dbCnt_r[i] != 8'hFF) begin
          dbCnt_r[i] <= dbCnt_r[i] + 8'h01;
        end
      end
    end
    // A qualifier edge restarts the gap, so both switches stay off meanwhile
    assign outA_nxt[i] = ctrlEn_r && aqLeg[i] && (aqLeg[i] == aqPrev_r[i])
                         && (dbCnt_r[i] >= dbVal[i]);
    assign outB_nxt[i] = ctrlEn_r && !aqLeg[i] && (aqLeg[i] == aqPrev_r[i])
                         && (dbCnt_r[i] >= dbVal[i]);
  end

  // Bridge outputs; trip forces the falling edge without waiting for the qualifier
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      leadingLegOutA <= 1'b0;
      leadingLegOutB <= 1'b0;
      laggingLegOutA <= 1'b0;
      laggingLegOutB <= 1'b0;
    end else begin
      leadingLegOutA <= outA_nxt[0];
      leadingLegOutB <= outB_nxt[0];
      laggingLegOutA <= outA_nxt[1] && !tripDown;
      laggingLegOutB <= outB_nxt[1] && !tripUp;
    end
  end

  // Rectifier mode changes only at zero or while stopped, so no pulse is cut short
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      srModeAct_r <= SR_OFF;
    end else if (zeroEvt || !ctrlEn_r) begin
      srModeAct_r <= pcpsp_srmode_t'(ctrlMode_r);
    end
  end

  // Rectifier drives from diagonal overlaps of the registered bridge outputs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      syncRectOut1 <= 1'b0;
      syncRectOut2 <= 1'b0;
    end else begin
      unique case (srModeAct_r)
        SR_DIODE: begin
          syncRectOut1 <= leadingLegOutA && laggingLegOutB;
          syncRectOut2 <= leadingLegOutB && laggingLegOutA;
        end
        SR_FULL: begin
          syncRectOut1 <= ctrlEn_r && !(leadingLegOutB && laggingLegOutA);
          syncRectOut2 <= ctrlEn_r && !(leadingLegOutA && laggingLegOutB);
        end
        SR_OFF, SR_SPARE: begin
          syncRectOut1 <= 1'b0;
          syncRectOut2 <= 1'b0;
        end
      endcase
    end
  end

  // Peak reference is taken once per period so both halves match
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rampStartAct_r <= RAMP_START_RST;
      rampSlopeAct_r <= RAMP_SLOPE_RST;
    end else if (zeroEvt || !ctrlEn_r) begin
      rampStartAct_r <= rampStartShadow_r;
      rampSlopeAct_r <= rampSlopeShadow_r;
    end
  end

  // Falling ramp: reload each half, saturate at zero; low nibble is the prescaler
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ramp_r <= 16'h0000;
    end else if (zeroEvt || !ctrlEn_r) begin
      ramp_r <= rampStartShadow_r;
    end else if (prdEvt) begin
      ramp_r <= rampStartAct_r;
    end else if (ramp_r > rampSlopeAct_r) begin
      ramp_r <= ramp_r - rampSlopeAct_r;
    end else begin
      ramp_r <= 16'h0000;
    end
  end

  // DAC code: ramp upper bits, or a flat reference when the ramp is off
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rampDacOut <= 12'h000;
    end else if (ctrlRampSel_r) begin
      rampDacOut <= ramp_r[15:4];
    end else begin
      rampDacOut <= rampStartAct_r[15:4];
    end
  end

  // Checks
  leadCompl_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(leadingLegOutA && leadingLegOutB)) else $error("leading outputs overlap");
  lagCompl_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(laggingLegOutA && laggingLegOutB)) else $error("lagging outputs overlap");
  tripForceA_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tripDown |=> !laggingLegOutA ##1 !laggingLegOutA) else $error("A not forced low");
  tripForceB_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    tripUp |=> !laggingLegOutB) else $error("B not forced low");
  aqUpSet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tripUp || prdEvt) |=> lagAq_r) else $error("lagging qualifier not set");
  aqZeroClr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (zeroEvt && !tripUp) |=> !lagAq_r) else $error("lagging qualifier not cleared");
  latchClr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ((zeroEvt || prdEvt) && !tripEvt) |=> !tripLatch_r) else $error("latch not cleared");
  srOff_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (srModeAct_r == SR_OFF) |=> !syncRectOut1 && !syncRectOut2) else $error("rect on in mode 0");
  modeAtZero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (srModeAct_r != $past(srModeAct_r)) |-> $past(zeroEvt || !ctrlEn_r))
    else $error("mode changed mid period");
  rampReload_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    prdEvt |=> ramp_r == rampStartAct_r) else $error("ramp not reloaded");
  dacMsb_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    ctrlRampSel_r |=> rampDacOut == $past(ramp_r[15:4])) else $error("dac code wrong");
  deadGap_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(laggingLegOutA) && dbLag_r > 8'h01 |=> !laggingLegOutB) else $error("no dead gap");

endmodule

// >>> verif/pcpsp_gate_model.sv
/*
  Far-side model: gate drivers plus the peak current comparator.
  Assumes the bridge leading leg starts power transfer and that the
  current reaches the reference a set number of cycles later.
*/
`timescale 1ns/1ps
module pcpsp_gate_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // Leading leg drives seen at the bridge
  input  wire logic       leadingLegOutA,
  input  wire logic       leadingLegOutB,
  // Cycles from transfer start to peak current
  input  wire logic [7:0] rampCycles,
  // Comparator output, asynchronous to the clock
  output logic            peakTripIn
);
  logic prevA;  // Last leading A level
  logic prevB;  // Last leading B level
  int   cnt;    // Cycles left until the current falls again

  // Current rises after each leading edge, stays above reference three cycles
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt = 0;
      prevA = 1'b0;
      prevB = 1'b0;
      peakTripIn <= 1'b0;
    end else begin
      if ((leadingLegOutA && !prevA) || (leadingLegOutB && !prevB))
        cnt = rampCycles + 3;
      else if (cnt > 0)
        cnt = cnt - 1;
      // Off the edge, as a real comparator would switch
      peakTripIn <= #3 (cnt inside {[1:3]});
      prevA = leadingLegOutA;
      prevB = leadingLegOutB;
    end
  end
endmodule

// >>> verif/tb.sv
/*
  Self-checking bench: registers, gate timing, rectifier modes and ramp.
  Assumes the gate model in pcpsp_gate_model.sv as the far side.
*/
`timescale 1ns/1ps
module tb;
  import pcpsp_pkg::*;
  logic        clk_sys, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, peakTripIn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rampCycles;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] rampDacOut, dacPrev, start;
  logic        leadingLegOutA, leadingLegOutB, laggingLegOutA, laggingLegOutB;
  logic        syncRectOut1, syncRectOut2;
  logic [4:0]  prv, now, rise, fall;  // Trip and gate levels, edges
  int          err_count, compares, cyc, tTrip, tLdA, tLdB, tLgA, tLgB;
  int          ov1, ov2, s1, s2, arm, mode, dbLead, dbLag, slope, rampM;
  bit          meas, ok;

  assign now  = {peakTripIn, leadingLegOutA, leadingLegOutB, laggingLegOutA, laggingLegOutB};
  assign rise = now & ~prv;
  assign fall = ~now & prv;

  pcpsp_top DUT (.clk_sys, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .peakTripIn, .rampDacOut,
    .leadingLegOutA, .leadingLegOutB, .laggingLegOutA, .laggingLegOutB,
    .syncRectOut1, .syncRectOut2);
  pcpsp_gate_model PART (.clk_sys, .nrst, .leadingLegOutA, .leadingLegOutB,
    .rampCycles, .peakTripIn);

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, r);
    @(posedge clk_sys);
  endtask

  // Read: one word, data and response taken at the rvalid edge
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, d);
    chk("rresp", s_axi_rresp, r);
    @(posedge clk_sys);
  endtask

  task automatic summarize();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Edge timing, rectifier pulse counts and ramp model, every clock
  always @(posedge clk_sys) begin
    if (meas) begin
      cyc++;
      ok = cyc > 90;  // One full period seen before gaps are trusted
      if (rise[4]) tTrip = cyc;
      if (fall[3]) tLdA = cyc;
      if (fall[2]) tLdB = cyc;
      if (fall[1]) tLgA = cyc;
      if (fall[0]) tLgB = cyc;
      if (ok) begin
        if (rise[2]) chk("lead b gap", cyc - tLdA, dbLead);
        if (rise[3]) chk("lead a gap", cyc - tLdB, dbLead);
        // A trip-forced fall comes on its qualifier edge, one clock before the unforced fall
        if (rise[1]) chk("lag a gap", cyc - tLgB, dbLag + (tLgB - tTrip == 3));
        if (rise[0]) chk("lag b gap", cyc - tLgA, dbLag + (tLgA - tTrip == 3));
        if (fall[1] | fall[0]) chk("trip to low", cyc - tTrip <= 3, 1);
        chk("lead overlap", now[3] & now[2], 0);
        chk("lag overlap", now[1] & now[0], 0);
      end
      ov1 += leadingLegOutA & laggingLegOutB;
      ov2 += leadingLegOutB & laggingLegOutA;
      s1 += syncRectOut1;
      s2 += syncRectOut2;
      // Ramp model: reload to the start code, else fall by the slope to zero
      if (rampDacOut > dacPrev) rampM = start;
      else rampM = rampM > slope ? rampM - slope : 0;
      if (ok && arm == 0) chk("ramp", rampDacOut, rampM);
      dacPrev = rampDacOut;
      if (rise[3]) begin
        if (arm > 0) arm--;
        else begin
          chk("sr1", s1, mode == 1 ? ov1 : mode == 2 ? 80 - ov2 : 0);
          chk("sr2", s2, mode == 1 ? ov2 : mode == 2 ? 80 - ov1 : 0);
        end
        {ov1, ov2, s1, s2} = '0;
      end
    end
    prv = now;
  end

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Watchdog: far longer than the whole sequence needs
  initial begin
    #200000;
    err_count++;
    summarize();
  end

  initial begin
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, prv, dacPrev, start} = '0;
    s_axi_wstrb = 4'hF;
    rampCycles = 8'h0A;
    void'($urandom(63));
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    axr(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(ADDR_PERIOD, 32'(PERIOD_RST), RESP_OKAY);
    axr(ADDR_DEADBAND, {16'h0, DB_RST, DB_RST}, RESP_OKAY);
    axr(8'h18, 32'h0, RESP_SLVERR);
    axw(ADDR_STATUS, 32'h0000FFFF, RESP_SLVERR);
    dbLead = $urandom_range(2, 5);
    dbLag = $urandom_range(2, 6);
    axw(ADDR_PERIOD, 32'h28, RESP_OKAY);
    axw(ADDR_DEADBAND, 32'((dbLag << 8) | dbLead), RESP_OKAY);
    axr(ADDR_DEADBAND, 32'((dbLag << 8) | dbLead), RESP_OKAY);
    // Every rectifier mode, with a fresh ramp and trip point each time
    for (int m = 0; m < 4; m++) begin
      arm = 3;
      slope = $urandom_range(1, 3);
      start = 12'($urandom_range(64, 4095));
      rampCycles <= 8'($urandom_range(8, 20));
      axw(ADDR_RAMP_SLOPE, 32'(slope << 4), RESP_OKAY);
      axw(ADDR_RAMP_START, {16'h0, start, 4'h0}, RESP_OKAY);
      axw(ADDR_CTRL, 32'((m << 2) | 3), RESP_OKAY);
      mode = m;
      meas = 1;
      repeat (m == 0 ? 1500 : 600) @(posedge clk_sys);
    end
    // Stopped block: live state settles, DAC shows the flat reference
    meas = 0;
    axw(ADDR_CTRL, 32'h0, RESP_OKAY);
    axr(ADDR_STATUS, {15'h0, 1'b1, start, 4'h0}, RESP_OKAY);
    chk("dac flat", rampDacOut, start);
    summarize();
  end
endmodule
